// ===== core/srsl_pkg.sv
// constants, register map and state types of the supervisor and status logic
package srsl_pkg;
   // clock and timing figures
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned RSTIN_MIN_NS = 100;
   localparam int unsigned RSTIN_MIN_CYC = (RSTIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TREC_DEF_US = 97000;
   localparam int unsigned TREC_STOP_US = 100000;
   localparam int unsigned TREC_LONG_US = 1000000;
   localparam int unsigned TREC_DEF_CYC = TREC_DEF_US * CLK_MHZ;
   localparam int unsigned TREC_STOP_CYC = TREC_STOP_US * CLK_MHZ;
   localparam int unsigned TREC_LONG_CYC = TREC_LONG_US * CLK_MHZ;
   localparam longint unsigned BATT_TEST_HOURS = 24;
   localparam longint unsigned BATT_TEST_CYC = BATT_TEST_HOURS * 64'd3600 * 64'(CLK_MHZ) * 64'd1000000;
   localparam int FILT_W = 4;
   localparam logic [FILT_W-1:0] FILT_TARGET = FILT_W'(RSTIN_MIN_CYC);
   localparam int CNT_W = 32;
   localparam int DAY_W = 44;

   // register offsets
   localparam logic [7:0] REG_HOURS = 8'h04;
   localparam logic [7:0] REG_YEARS = 8'h07;
   localparam logic [7:0] REG_CTRL = 8'h0A;
   localparam logic [7:0] REG_FLAGS = 8'h0F;
   localparam logic [7:0] REG_SERIAL = 8'h18;
   localparam logic [4:0] SERIAL_BASE = 5'h03;

   // field positions
   localparam int HOURS_TR_BIT = 7;
   localparam int YEARS_CENT_HI = 7;
   localparam int YEARS_CENT_LO = 6;
   localparam int FLAG_BL_BIT = 4;
   localparam int FLAG_OF_BIT = 2;
   localparam int CTRL_OUT_BIT = 7;
   localparam int CTRL_ABE_BIT = 6;
   localparam int CTRL_AFE_BIT = 5;
   localparam int CTRL_OSC_FAIL_IRQ_ENABLE_BIT = 4;
   localparam int CTRL_TIE_BIT = 3;
   localparam int CTRL_WDIRQ_BIT = 2;
   localparam int CTRL_POWERFAIL_OPENDRAIN_SEL_BIT = 1;
   localparam int CTRL_ST_BIT = 0;

   // serial number, arbitrary value
   localparam logic [63:0] SERIAL_DEFAULT = 64'h0123_4567_89AB_CDEF;

   // reset phases of the supervisor
   typedef enum logic [1:0] {PH_BACKUP, PH_HOLD, PH_RECOVER, PH_RUN} srsl_phase_e;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } srsl_req_s;

   // whole state of the supervisor
   typedef struct packed {
      srsl_phase_e phase;
      logic powerRecov;
      logic [CNT_W-1:0] recCnt;
      logic fallMeta;
      logic fallSync;
      logic riseMeta;
      logic riseSync;
      logic [FILT_W-1:0] fallCnt;
      logic [FILT_W-1:0] riseCnt;
      logic vccSeen;
      logic [DAY_W-1:0] dayCnt;
      logic tr;
      logic [7:0] ctrl;
      logic [5:0] hours;
      logic [1:0] century;
      logic oscFail;
      logic battLow;
      logic rdPend;
      logic [7:0] rdAddr;
      logic [7:0] rdData;
      logic rdValid;
      logic resetLow;
      logic pfOutA;
      logic pfOeA;
      logic pfOutB;
      logic pfOeB;
      logic irqLow;
      logic leapDay;
   } srsl_state_s;

   localparam srsl_state_s STATE_RESET = '{
      phase: PH_BACKUP, powerRecov: 1'b1, recCnt: '0, fallMeta: 1'b1, fallSync: 1'b1,
      riseMeta: 1'b0, riseSync: 1'b0, fallCnt: '0, riseCnt: '0, vccSeen: 1'b0,
      dayCnt: '0, tr: 1'b0, ctrl: 8'h82, hours: '0, century: '0, oscFail: 1'b1,
      battLow: 1'b0, rdPend: 1'b0, rdAddr: '0, rdData: '0, rdValid: 1'b0,
      resetLow: 1'b1, pfOutA: 1'b0, pfOeA: 1'b1, pfOutB: 1'b0, pfOeB: 1'b1,
      irqLow: 1'b0, leapDay: 1'b0};
endpackage

// ===== core/srsl_serial_rom.sv
// read-only store of the eight serial number bytes
`timescale 1ns/1ps
module srsl_serial_rom
   import srsl_pkg::*;
#(
   parameter logic [63:0] SERIAL = SERIAL_DEFAULT
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [2:0] addr,
   output logic [7:0] data
);
   logic [7:0] bytes [8];

   // one byte per entry, fixed at build time
   for (genvar i = 0; i < 8; i++)
   begin : g_byte
      assign bytes[i] = SERIAL[i*8 +: 8];
   end

   // registered read port
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         data <= '0;
      else
         data <= bytes[addr];
   end
endmodule // srsl_serial_rom

// ===== core/srsl_supervisor.sv
// supervisor, power-fail outputs, interrupt pin and status registers
`timescale 1ns/1ps
module srsl_supervisor
   import srsl_pkg::*;
#(
   parameter int unsigned TREC_DEF = TREC_DEF_CYC,
   parameter int unsigned TREC_STOP = TREC_STOP_CYC,
   parameter int unsigned TREC_LONG = TREC_LONG_CYC,
   parameter longint unsigned BATT_PERIOD = BATT_TEST_CYC
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic extResetFall_n,
   input wire logic extResetRise,
   input wire logic vccOk,
   input wire logic pfBelowA,
   input wire logic pfBelowB,
   input wire logic batteryBelow,
   input wire logic oscStopped,
   input wire logic alarmEvent,
   input wire logic watchdogEvent,
   input wire logic tamperEvent,
   input wire logic watchdogReset,
   input wire logic centuryRoll,
   input wire logic [7:0] yearBcd,
   input wire srsl_req_s regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   output logic resetLow,
   output logic pfOutA,
   output logic pfOeA,
   output logic pfOutB,
   output logic pfOeB,
   output logic irqLow,
   output logic leapDay,
   output logic [1:0] centuryBits
);
   srsl_state_s s;
   srsl_state_s next_s;
   logic [7:0] serialByte;
   logic fallReq;
   logic riseReq;
   logic anyReq;
   logic [CNT_W-1:0] recLen;
   logic wrOk;
   logic irqSrcOn;
   logic irqAssert;
   logic yearDiv4;
   logic centuryYear;

   // serial number store, addressed by the low offset bits
   srsl_serial_rom srsl_serial_rom_i (
      .clock(clock),
      .arst_n(arst_n),
      .addr(regReq.addr[2:0]),
      .data(serialByte)
   );

   // filtered reset requests and merged request
   assign fallReq = (s.fallCnt == FILT_TARGET);
   assign riseReq = (s.riseCnt == FILT_TARGET);
   assign anyReq = fallReq | riseReq | watchdogReset | !vccOk;

   // recovery length select
   always_comb
   begin
      if (s.tr)
         recLen = CNT_W'(TREC_LONG);
      else if (s.ctrl[CTRL_ST_BIT])
         recLen = CNT_W'(TREC_STOP);
      else
         recLen = CNT_W'(TREC_DEF);
   end

   // writes accepted only while running normally
   assign wrOk = regReq.wr && (s.phase == PH_RUN);

   // interrupt sources
   assign irqSrcOn = s.ctrl[CTRL_OSC_FAIL_IRQ_ENABLE_BIT] | s.ctrl[CTRL_AFE_BIT] | s.ctrl[CTRL_TIE_BIT]
                     | s.ctrl[CTRL_WDIRQ_BIT];
   assign irqAssert = (s.oscFail & s.ctrl[CTRL_OSC_FAIL_IRQ_ENABLE_BIT])
                      | (alarmEvent & s.ctrl[CTRL_AFE_BIT])
                      | (tamperEvent & s.ctrl[CTRL_TIE_BIT])
                      | (watchdogEvent & s.ctrl[CTRL_WDIRQ_BIT]);

   // leap year test on the bcd year
   assign yearDiv4 = yearBcd[4] ? (yearBcd[3:0] == 4'h2 || yearBcd[3:0] == 4'h6)
                                : (yearBcd[3:0] == 4'h0 || yearBcd[3:0] == 4'h4
                                   || yearBcd[3:0] == 4'h8);
   assign centuryYear = (yearBcd == 8'h00);

   // next state
   always_comb
   begin
      next_s = s;

      // two-flop synchronisers on the reset inputs
      next_s.fallMeta = extResetFall_n;
      next_s.fallSync = s.fallMeta;
      next_s.riseMeta = extResetRise;
      next_s.riseSync = s.riseMeta;

      // width filters: count active cycles, saturate at the minimum width
      if (s.fallSync)
         next_s.fallCnt = '0;
      else if (!fallReq)
         next_s.fallCnt = s.fallCnt + FILT_W'(1);
      if (!s.riseSync)
         next_s.riseCnt = '0;
      else if (!riseReq)
         next_s.riseCnt = s.riseCnt + FILT_W'(1);

      // reset phase sequence
      case (s.phase)
         PH_BACKUP:
         begin
            if (vccOk)
            begin
               next_s.phase = PH_RECOVER;
               next_s.recCnt = recLen;
            end
         end
         PH_HOLD:
         begin
            if (!vccOk)
               next_s.phase = PH_BACKUP;
            else if (!anyReq)
            begin
               next_s.phase = PH_RECOVER;
               next_s.recCnt = recLen;
            end
         end
         PH_RECOVER:
         begin
            if (!vccOk)
               next_s.phase = PH_BACKUP;
            else if (anyReq)
               next_s.phase = PH_HOLD;
            else if (s.recCnt <= CNT_W'(1))
            begin
               next_s.phase = PH_RUN;
               next_s.powerRecov = 1'b0;
            end
            else
               next_s.recCnt = s.recCnt - CNT_W'(1);
         end
         PH_RUN:
         begin
            if (!vccOk)
               next_s.phase = PH_BACKUP;
            else if (anyReq)
               next_s.phase = PH_HOLD;
         end
         default:
            next_s.phase = PH_BACKUP;
      endcase
      if (!vccOk)
         next_s.powerRecov = 1'b1;

      // reset or supply return clears enables; backup keeps them for the pin
      if (next_s.phase == PH_HOLD || next_s.phase == PH_RECOVER)
      begin
         next_s.ctrl[CTRL_OSC_FAIL_IRQ_ENABLE_BIT] = 1'b0;
         next_s.ctrl[CTRL_AFE_BIT] = 1'b0;
         next_s.ctrl[CTRL_ABE_BIT] = 1'b0;
         next_s.ctrl[CTRL_TIE_BIT] = 1'b0;
         next_s.ctrl[CTRL_WDIRQ_BIT] = 1'b0;
      end

      // battery test at power-up and every period, only with supply
      next_s.vccSeen = vccOk;
      if (!vccOk)
         next_s.dayCnt = '0;
      else if (!s.vccSeen || s.dayCnt >= DAY_W'(BATT_PERIOD - 64'd1))
      begin
         next_s.dayCnt = '0;
         next_s.battLow = batteryBelow;
      end
      else
         next_s.dayCnt = s.dayCnt + DAY_W'(1);

      // century counter
      if (centuryRoll)
         next_s.century = s.century + 2'b01;

      // register writes
      if (wrOk)
      begin
         if (regReq.addr == REG_HOURS)
         begin
            next_s.tr = regReq.wdata[HOURS_TR_BIT];
            next_s.hours = regReq.wdata[5:0];
         end
         else if (regReq.addr == REG_YEARS)
            next_s.century = {regReq.wdata[YEARS_CENT_HI], regReq.wdata[YEARS_CENT_LO]};
         else if (regReq.addr == REG_CTRL)
            next_s.ctrl = regReq.wdata;
         else if (regReq.addr == REG_FLAGS && !regReq.wdata[FLAG_OF_BIT])
            next_s.oscFail = 1'b0;
      end

      // oscillator fail set wins over a clearing write
      if (oscStopped || s.ctrl[CTRL_ST_BIT])
         next_s.oscFail = 1'b1;

      // register reads, answered two cycles after the request
      next_s.rdPend = regReq.rd;
      next_s.rdAddr = regReq.addr;
      next_s.rdValid = s.rdPend;
      if (s.rdPend)
      begin
         if (s.rdAddr == REG_HOURS)
            next_s.rdData = {s.tr, 1'b0, s.hours};
         else if (s.rdAddr == REG_YEARS)
            next_s.rdData = {s.century, 6'h00};
         else if (s.rdAddr == REG_CTRL)
            next_s.rdData = s.ctrl;
         else if (s.rdAddr == REG_FLAGS)
            next_s.rdData = 8'(({7'h00, s.battLow} << FLAG_BL_BIT)
                                | ({7'h00, s.oscFail} << FLAG_OF_BIT));
         else if (s.rdAddr[7:3] == SERIAL_BASE)
            next_s.rdData = serialByte;
         else
            next_s.rdData = 8'h00;
      end

      // reset output from the phase
      next_s.resetLow = (next_s.phase != PH_RUN);

      // power-fail outputs
      if (!vccOk)
      begin
         next_s.pfOutA = 1'b0;
         next_s.pfOutB = 1'b0;
      end
      else if (next_s.powerRecov)
      begin
         next_s.pfOutA = 1'b1;
         next_s.pfOutB = 1'b1;
      end
      else
      begin
         next_s.pfOutA = !pfBelowA;
         next_s.pfOutB = !pfBelowB;
      end
      next_s.pfOeA = !next_s.ctrl[CTRL_POWERFAIL_OPENDRAIN_SEL_BIT] | !next_s.pfOutA;
      next_s.pfOeB = !next_s.ctrl[CTRL_POWERFAIL_OPENDRAIN_SEL_BIT] | !next_s.pfOutB;

      // interrupt and output pin
      if (!vccOk && !s.ctrl[CTRL_ABE_BIT])
         next_s.irqLow = 1'b0;
      else if (irqSrcOn)
         next_s.irqLow = irqAssert;
      else
         next_s.irqLow = !s.ctrl[CTRL_OUT_BIT];

      // leap day allowed for the current year
      next_s.leapDay = yearDiv4 & (!centuryYear | (s.century == 2'b00));
   end

   // state register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         s <= STATE_RESET;
      else
         s <= next_s;
   end

   // outputs straight from the state register
   assign regRdData = s.rdData;
   assign regRdValid = s.rdValid;
   assign resetLow = s.resetLow;
   assign pfOutA = s.pfOutA;
   assign pfOeA = s.pfOeA;
   assign pfOutB = s.pfOutB;
   assign pfOeB = s.pfOeB;
   assign irqLow = s.irqLow;
   assign leapDay = s.leapDay;
   assign centuryBits = s.century;
endmodule // srsl_supervisor

// ===== test/srsl_supervisor_sva.sv
// assertions on the ports of the supervisor
`timescale 1ns/1ps
module srsl_supervisor_sva
   import srsl_pkg::*;
#(
   parameter int unsigned TREC_DEF = TREC_DEF_CYC
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic extResetFall_n,
   input wire logic extResetRise,
   input wire logic vccOk,
   input wire logic pfBelowA,
   input wire logic pfBelowB,
   input wire logic centuryRoll,
   input wire logic [7:0] yearBcd,
   input wire srsl_req_s regReq,
   input wire logic resetLow,
   input wire logic pfOutA,
   input wire logic pfOeA,
   input wire logic pfOutB,
   input wire logic pfOeB,
   input wire logic irqLow,
   input wire logic leapDay,
   input wire logic [1:0] centuryBits
);
   logic [31:0] lowRun;
   logic abeSet;

   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   // length of the present reset output pulse
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         lowRun <= '0;
      else
         lowRun <= resetLow ? lowRun + 32'h1 : '0;
   end

   // backup-alarm enable as last written while running; a reset with supply clears it
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         abeSet <= 1'b0;
      else if (resetLow && vccOk)
         abeSet <= 1'b0;
      else if (regReq.wr && !resetLow && regReq.addr == REG_CTRL)
         abeSet <= regReq.wdata[CTRL_ABE_BIT];
   end

   // leap year of a bcd year within its century code
   function automatic logic leap(logic [7:0] y, logic [1:0] c);
      if (y == 8'h00)
         return c == 2'h0;
      return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
         : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
   endfunction

   pf_backup_a: assert property (
      !vccOk [*3] |-> !pfOutA && !pfOutB) else $error("power-fail output high in backup");
   pf_follow_a: assert property (
      (vccOk && !resetLow && pfBelowA) [*4] |-> !pfOutA) else $error("output a not low");
   pf_high_a: assert property (
      (vccOk && !resetLow && !pfBelowB) [*4] |-> pfOutB) else $error("output b not high");
   pf_drive_a: assert property (
      (pfOutA || pfOeA) && (pfOutB || pfOeB)) else $error("low level not driven");
   fall_reset_a: assert property (
      !extResetFall_n [*8] |=> resetLow) else $error("falling input gave no reset");
   rise_reset_a: assert property (
      extResetRise [*8] |=> resetLow) else $error("rising input gave no reset");
   rec_min_a: assert property (
      $fell(resetLow) |-> lowRun >= TREC_DEF - 2) else $error("recovery too short");
   leap_day_a: assert property (
      $past(arst_n) && $stable(yearBcd) && $stable(centuryBits)
      |-> leapDay == leap(yearBcd, centuryBits)) else $error("leap day wrong");
   century_step_a: assert property (
      centuryRoll |=> centuryBits == $past(centuryBits) + 2'h1) else $error("century not stepped");
   backup_irq_a: assert property (
      (!vccOk && !abeSet) [*3] |-> !irqLow) else $error("interrupt pin driven in backup");
endmodule // srsl_supervisor_sva

// ===== test/srsl_host_model.sv
// host that clears the oscillator fail flag only after a settled run
`timescale 1ns/1ps
module srsl_host_model
#(
   parameter int unsigned RUN_HOLD = 40
)(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic oscRun,
   input wire logic resetLow,
   output logic clearOk
);
   logic [15:0] runCnt;

   // count running oscillator cycles, restart on every stop
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         runCnt <= '0;
      else if (!oscRun)
         runCnt <= '0;
      else if (runCnt < 16'(RUN_HOLD))
         runCnt <= runCnt + 16'h1;
   end

   // clearing allowed only after the settle time and out of reset
   assign clearOk = runCnt >= 16'(RUN_HOLD) && !resetLow;
endmodule // srsl_host_model

// ===== test/tb_srsl_supervisor.sv
// testbench of the supervisor with host model and read scoreboard
`timescale 1ns/1ps
module tb_srsl_supervisor
   import srsl_pkg::*;
;
   localparam int TD = 50;
   localparam int TS = 60;
   localparam int TL = 80;
   localparam int TB = 200;
   logic clock, arst_n, extResetFall_n, extResetRise, vccOk, pfBelowA, pfBelowB;
   logic batteryBelow, oscStopped, centuryRoll, st, clearOk, regRdValid, resetLow;
   logic pfOutA, pfOeA, pfOutB, pfOeB, irqLow, leapDay;
   logic alarmEvent, watchdogEvent, tamperEvent, watchdogReset;
   logic [7:0] yearBcd, regRdData;
   logic [1:0] centuryBits;
   logic [31:0] seed = 32'h66FD;
   logic [15:0] rdq[$];
   srsl_req_s regReq;
   int errTotal = 0, nTests = 0;

   srsl_supervisor #(.TREC_DEF(TD), .TREC_STOP(TS), .TREC_LONG(TL), .BATT_PERIOD(TB))
   srsl_supervisor_i (.clock, .arst_n, .extResetFall_n, .extResetRise, .vccOk, .pfBelowA,
      .pfBelowB, .batteryBelow, .oscStopped, .alarmEvent, .watchdogEvent,
      .tamperEvent, .watchdogReset, .centuryRoll, .yearBcd, .regReq, .regRdData,
      .regRdValid, .resetLow, .pfOutA, .pfOeA, .pfOutB, .pfOeB, .irqLow, .leapDay, .centuryBits);
   srsl_host_model #(.RUN_HOLD(40)) srsl_host_model_i (.clock, .arst_n,
      .oscRun(!oscStopped && !st), .resetLow, .clearOk);

   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(logic [15:0] s, logic [15:0] e);
      nTests++;
      if (s !== e)
      begin
         errTotal++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // one register access; reads note the masked expectation
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e, logic [7:0] m);
      regReq = '{wr: w, rd: !w, addr: a, wdata: d};
      if (!w)
         rdq.push_back({m, e & m});
      cyc(1);
      regReq = '0;
      cyc(1);
   endtask

   // cycles until the reset output releases, bounded
   task automatic rel(output int n);
      n = 0;
      while (resetLow !== 1'b0 && n < 3000)
      begin
         cyc(1);
         n++;
      end
   endtask

   task automatic test_done();
      if (errTotal == 0 && nTests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // clock
   initial
   begin
      clock = 0;
      forever #10 clock = ~clock;
   end

   // compare each read answer with the oldest note
   always @(posedge clock)
   begin
      logic [15:0] q;
      #2;
      if (regRdValid === 1'b1)
      begin
         q = (rdq.size() == 0) ? 16'hFFFF : rdq.pop_front();
         chk(16'(regRdData & q[15:8]), 16'(q[7:0]));
      end
   end

   // hang guard
   initial
   begin
      #200000;
      errTotal++;
      test_done();
   end

   // main sequence
   initial
   begin
      int n;
      int len;
      arst_n = 0;
      extResetFall_n = 1;
      extResetRise = 0;
      vccOk = 1;
      pfBelowA = 0;
      pfBelowB = 0;
      batteryBelow = 0;
      oscStopped = 0;
      {alarmEvent, watchdogEvent, tamperEvent, watchdogReset} = 4'h0;
      centuryRoll = 0;
      st = 0;
      yearBcd = 8'h00;
      regReq = '0;
      cyc(5);
      arst_n = 1;
      acc(0, REG_FLAGS, 0, 8'h04, 8'hFF);
      acc(0, REG_CTRL, 0, 8'h82, 8'hFF);
      acc(0, 8'h30, 0, 8'h00, 8'hFF);
      acc(1, REG_HOURS, 8'h80, 0, 0);
      rel(n);
      chk(16'(n <= TD + 10), 16'h1);
      acc(0, REG_HOURS, 0, 8'h00, 8'h80);
      // serial number ignores writes
      acc(1, REG_SERIAL, 8'h5A, 0, 0);
      acc(0, REG_SERIAL, 0, SERIAL_DEFAULT[7:0], 8'hFF);
      acc(0, REG_SERIAL + 8'h07, 0, SERIAL_DEFAULT[63:56], 8'hFF);
      // short pulse must be rejected
      extResetFall_n = 0;
      cyc(4);
      extResetFall_n = 1;
      cyc(12);
      chk(resetLow, 0);
      // recovery length for each select and stop setting
      for (int i = 0; i < 3; i++)
      begin
         st = i[0];
         len = (i == 0) ? TD : (i == 1) ? TS : TL;
         acc(1, REG_HOURS, {i[1], 7'h0}, 0, 0);
         acc(1, REG_CTRL, {7'h49, st}, 0, 0);
         cyc(2);
         chk(irqLow, 1);
         if (i == 1)
            extResetRise = 1;
         else
            extResetFall_n = 0;
         cyc(12);
         chk({resetLow, irqLow}, 2'b10);
         extResetRise = 0;
         extResetFall_n = 1;
         rel(n);
         chk(16'(n >= len && n <= len + 10), 16'h1);
         acc(0, REG_CTRL, 0, {7'h41, st}, 8'hFF);
      end
      acc(1, REG_HOURS, 8'h00, 0, 0);
      acc(1, REG_CTRL, 8'h82, 0, 0);
      st = 0;
      // oscillator fail flag and interrupt pin
      rel(n);
      n = 0;
      while (clearOk !== 1'b1 && n < 500)
      begin
         cyc(1);
         n++;
      end
      acc(1, REG_FLAGS, 8'h00, 0, 0);
      acc(0, REG_FLAGS, 0, 8'h00, 8'h04);
      acc(1, REG_CTRL, 8'h92, 0, 0);
      oscStopped = 1;
      cyc(3);
      acc(0, REG_FLAGS, 0, 8'h04, 8'h04);
      chk(irqLow, 1);
      oscStopped = 0;
      {alarmEvent, watchdogEvent, tamperEvent} = 3'h7;
      acc(1, REG_CTRL, 8'h82, 0, 0);
      cyc(2);
      chk(irqLow, 0);
      acc(1, REG_CTRL, 8'h02, 0, 0);
      cyc(2);
      chk(irqLow, 1);
      {alarmEvent, watchdogEvent, tamperEvent} = 3'h0;
      acc(1, REG_CTRL, 8'h82, 0, 0);
      // watchdog request in mid-recovery restarts the count
      watchdogReset = 1;
      cyc(2);
      watchdogReset = 0;
      cyc(20);
      watchdogReset = 1;
      cyc(1);
      watchdogReset = 0;
      rel(n);
      chk(16'(n >= TD && n <= TD + 10), 16'h1);
      // open drain, backup-alarm enable, output bit low
      acc(1, REG_CTRL, 8'h42, 0, 0);
      // comparators follow their inputs in normal operation
      for (int k = 0; k < 8; k++)
      begin
         seed = xs(seed);
         pfBelowA = seed[0];
         pfBelowB = seed[1];
         cyc(5);
         chk({pfOutA, pfOutB}, {!seed[0], !seed[1]});
         chk({pfOeA, pfOeB}, {seed[0], seed[1]});
      end
      // push-pull, backup-alarm enable kept, output bit low
      acc(1, REG_CTRL, 8'h40, 0, 0);
      // backup, supply return and battery test
      pfBelowA = 1;
      pfBelowB = 1;
      batteryBelow = 1;
      vccOk = 0;
      cyc(5);
      chk({resetLow, pfOutA, pfOutB, irqLow}, 4'h9);
      acc(1, REG_HOURS, 8'h80, 0, 0);
      vccOk = 1;
      cyc(5);
      chk({pfOutA, pfOutB, pfOeA, pfOeB}, 4'hF);
      rel(n);
      chk(16'(n >= TD - 10 && n <= TD + 10), 16'h1);
      cyc(5);
      chk({pfOutA, pfOutB}, 2'h0);
      acc(0, REG_CTRL, 0, 8'h00, 8'hFF);
      // short second backup with the backup-alarm enable cleared
      vccOk = 0;
      cyc(3);
      chk(irqLow, 0);
      vccOk = 1;
      acc(0, REG_HOURS, 0, 8'h00, 8'h80);
      acc(0, REG_FLAGS, 0, 8'h10, 8'h10);
      batteryBelow = 0;
      cyc(TB + 10);
      acc(0, REG_FLAGS, 0, 8'h00, 8'h10);
      // century steps through all four codes
      for (int k = 1; k < 5; k++)
      begin
         centuryRoll = 1;
         cyc(1);
         centuryRoll = 0;
         yearBcd = 8'h00;
         cyc(3);
         acc(0, REG_YEARS, 0, {k[1:0], 6'h0}, 8'hC0);
         seed = xs(seed);
         yearBcd = {seed[7:4] % 4'hA, seed[3:0] % 4'hA};
         cyc(3);
      end
      cyc(4);
      chk(16'(rdq.size()), 16'h0);
      test_done();
   end
endmodule // tb_srsl_supervisor

bind srsl_supervisor srsl_supervisor_sva #(.TREC_DEF(TREC_DEF)) srsl_supervisor_sva_i (
   .clock, .arst_n, .extResetFall_n, .extResetRise, .vccOk, .pfBelowA, .pfBelowB,
   .centuryRoll, .yearBcd, .regReq, .resetLow, .pfOutA, .pfOeA, .pfOutB, .pfOeB, .irqLow,
   .leapDay,
   .centuryBits);
